// file: shared/iod_pkg.sv
/*
  Constants, types and decode functions for the 64-location I/O register space.
  Assumes one core clock and an execution unit that issues at most one access per cycle.
*/
`default_nettype none
package iod_pkg;
  localparam int IO_LOCS = 64;
  localparam int IO_ADDR_W = 6; // 64 locations, no more
  localparam int BIT_ADDR_W = 5; // bit ops reach the low 32 only
  localparam int PORT_COUNT = 4;
  localparam int PORT_STRIDE = 3; // pins, direction, latch per port
  localparam int DATA_W = 16;

  typedef logic [IO_ADDR_W-1:0] iod_addr_t;
  typedef logic [7:0] iod_byte_t;
  typedef logic [IO_LOCS-1:0][7:0] iod_image_t;
  typedef logic [PORT_COUNT-1:0][7:0] iod_ports_t;

  // data-space windows
  localparam logic [DATA_W-1:0] DATA_IO_FIRST = 16'h0020;
  localparam logic [DATA_W-1:0] DATA_IO_LAST = 16'h005F;
  localparam logic [DATA_W-1:0] DATA_EXT_FIRST = 16'h0060;
  localparam logic [DATA_W-1:0] DATA_EXT_LAST = 16'h00FF;
  localparam iod_byte_t IO_RESET_VALUE = 8'h00;

  // native offsets
  localparam iod_addr_t A_PORT_A_INPUT_PINS = 6'h00;
  localparam iod_addr_t A_TIMER0_EVENT_FLAGS = 6'h15;
  localparam iod_addr_t A_TIMER1_EVENT_FLAGS = 6'h16;
  localparam iod_addr_t A_TIMER2_EVENT_FLAGS = 6'h17;
  localparam iod_addr_t A_PIN_CHANGE_GROUP_FLAGS = 6'h1B;
  localparam iod_addr_t A_EXTERNAL_IRQ_FLAGS = 6'h1C;
  localparam iod_addr_t A_EXTERNAL_IRQ_MASK = 6'h1D;
  localparam iod_addr_t A_GENERAL_SCRATCH_0 = 6'h1E;
  localparam iod_addr_t A_EEPROM_CONTROL = 6'h1F;
  localparam iod_addr_t A_EEPROM_DATA = 6'h20;
  localparam iod_addr_t A_EEPROM_ADDRESS_LOW = 6'h21;
  localparam iod_addr_t A_EEPROM_ADDRESS_HIGH = 6'h22;
  localparam iod_addr_t A_TIMER_PRESCALER_SYNC_CTRL = 6'h23;
  localparam iod_addr_t A_TIMER0_CONTROL_A = 6'h24;
  localparam iod_addr_t A_TIMER0_CONTROL_B = 6'h25;
  localparam iod_addr_t A_TIMER0_COUNT_VALUE = 6'h26;
  localparam iod_addr_t A_TIMER0_COMPARE_A = 6'h27;
  localparam iod_addr_t A_TIMER0_COMPARE_B = 6'h28;
  localparam iod_addr_t A_GENERAL_SCRATCH_1 = 6'h2A;
  localparam iod_addr_t A_GENERAL_SCRATCH_2 = 6'h2B;
  localparam iod_addr_t A_SERIAL_PERIPH_CONTROL = 6'h2C;
  localparam iod_addr_t A_SERIAL_PERIPH_STATE = 6'h2D;
  localparam iod_addr_t A_SERIAL_PERIPH_SHIFT_DATA = 6'h2E;
  localparam iod_addr_t A_COMPARATOR_CONTROL_STATE = 6'h30;
  localparam iod_addr_t A_DEBUG_EXCHANGE = 6'h31;
  localparam iod_addr_t A_SLEEP_MODE_CONTROL = 6'h33;
  localparam iod_addr_t A_RESET_CAUSE_FLAGS = 6'h34;
  localparam iod_addr_t A_CORE_MISC_CONTROL = 6'h35;
  localparam iod_addr_t A_PORT_LAST = 6'h0B;

  typedef enum logic [3:0] {
    OP_IDLE, OP_IO_READ, OP_IO_WRITE, OP_MEM_READ, OP_MEM_WRITE,
    OP_SET_BIT, OP_CLEAR_BIT, OP_SKIP_IF_SET, OP_SKIP_IF_CLEAR
  } iod_op_t;

  typedef struct packed {
    iod_op_t op;
    iod_addr_t io_addr;
    logic [BIT_ADDR_W-1:0] bit_addr;
    logic [2:0] bit_sel;
    logic [DATA_W-1:0] data_addr;
    iod_byte_t wdata;
  } iod_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic skip;
    iod_byte_t rdata;
  } iod_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    iod_byte_t wdata;
  } iod_ext_t;

  typedef struct packed {
    iod_image_t regs;
    iod_ports_t pin_meta;
    iod_ports_t pin_sync;
    iod_rsp_t rsp;
    iod_ext_t ext;
  } iod_state_t;

  // implemented bits per location; all else reads zero
  function automatic iod_byte_t impl_mask(input iod_addr_t a);
    if (a <= A_PORT_LAST) return 8'hFF;
    case (a)
      A_TIMER0_EVENT_FLAGS, A_TIMER2_EVENT_FLAGS, A_EXTERNAL_IRQ_FLAGS,
      A_EXTERNAL_IRQ_MASK: return 8'h07;
      A_TIMER1_EVENT_FLAGS: return 8'h27;
      A_PIN_CHANGE_GROUP_FLAGS, A_EEPROM_ADDRESS_HIGH, A_SLEEP_MODE_CONTROL: return 8'h0F;
      A_EEPROM_CONTROL: return 8'h3F;
      A_TIMER_PRESCALER_SYNC_CTRL: return 8'h83;
      A_TIMER0_CONTROL_A, A_CORE_MISC_CONTROL: return 8'hF3;
      A_TIMER0_CONTROL_B: return 8'hCF;
      A_SERIAL_PERIPH_STATE: return 8'hC1;
      A_RESET_CAUSE_FLAGS: return 8'h1F;
      A_GENERAL_SCRATCH_0, A_EEPROM_DATA, A_EEPROM_ADDRESS_LOW, A_TIMER0_COUNT_VALUE,
      A_TIMER0_COMPARE_A, A_TIMER0_COMPARE_B, A_GENERAL_SCRATCH_1, A_GENERAL_SCRATCH_2,
      A_SERIAL_PERIPH_CONTROL, A_SERIAL_PERIPH_SHIFT_DATA, A_COMPARATOR_CONTROL_STATE,
      A_DEBUG_EXCHANGE: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  // flags cleared by writing one
  function automatic iod_byte_t w1c_mask(input iod_addr_t a);
    case (a)
      A_TIMER0_EVENT_FLAGS, A_TIMER1_EVENT_FLAGS, A_TIMER2_EVENT_FLAGS,
      A_PIN_CHANGE_GROUP_FLAGS, A_EXTERNAL_IRQ_FLAGS: return impl_mask(a);
      A_COMPARATOR_CONTROL_STATE: return 8'h10;
      default: return 8'h00;
    endcase
  endfunction

  // bits that follow a hardware level and ignore writes
  function automatic iod_byte_t ro_mask(input iod_addr_t a);
    if (a <= A_PORT_LAST && (int'(a) % PORT_STRIDE) == 0) return 8'hFF;
    case (a)
      A_SERIAL_PERIPH_STATE: return 8'hC0;
      A_COMPARATOR_CONTROL_STATE: return 8'h20;
      default: return 8'h00;
    endcase
  endfunction

  // bits a hardware event may set
  function automatic iod_byte_t set_mask(input iod_addr_t a);
    if (a == A_RESET_CAUSE_FLAGS) return impl_mask(a);
    return w1c_mask(a);
  endfunction

  // store a written byte: levels kept, flags cleared by ones, plain bits stored
  function automatic iod_byte_t apply_write(input iod_byte_t old, input iod_byte_t wv,
                                            input iod_addr_t a);
    iod_byte_t plain;
    plain = impl_mask(a) & ~ro_mask(a) & ~w1c_mask(a);
    return (old & ro_mask(a)) | (old & w1c_mask(a) & ~wv) | (wv & plain);
  endfunction
endpackage
`default_nettype wire

// file: tb/io_space_address_decoder_tb.sv
/* self-checking bench for the I/O space decoder.
   assumes the bound checker and the execution unit model. */
`default_nettype none
module io_space_address_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  iod_pkg::iod_req_t req;
  iod_pkg::iod_ports_t pins = 32'hC3A50F96;
  iod_pkg::iod_image_t hw_set = '0;
  iod_pkg::iod_image_t hw_status = '0;
  iod_pkg::iod_rsp_t rsp;
  iod_pkg::iod_ext_t ext;
  iod_pkg::iod_image_t image;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] ext_a [2] = '{16'h0060, 16'h00FF};
  iod_io_space dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .pins_i(pins), .hw_set_i(hw_set), .hw_status_i(hw_status), .rsp_o(rsp), .ext_o(ext),
    .io_image_o(image));
  iod_exec_model core_u (.ref_clk_i(ref_clk_i), .req_o(req));
  // 20 MHz core clock; hang guard far above the run length
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input iod_pkg::iod_op_t op, input logic [15:0] a, input logic [7:0] d);
    core_u.issue(op, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    acc(iod_pkg::OP_IO_READ, a, 8'h00);
    check(what, exp, rsp.rdata);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i) sys_rst_i = 1'b0;
    check("image zero after reset", 16'h0000, 16'(|image));
    // native and aliased access, 6-bit native field
    acc(iod_pkg::OP_IO_WRITE, 16'h001E, 8'hA5);
    rd(16'h001E, 8'hA5, "scratch0 native");
    acc(iod_pkg::OP_MEM_READ, 16'h003E, 8'h00);
    check("scratch0 alias", 16'h00A5, rsp.rdata);
    acc(iod_pkg::OP_MEM_WRITE, 16'h004B, 8'h3C);
    rd(16'h002B, 8'h3C, "scratch2 native");
    acc(iod_pkg::OP_MEM_READ, 16'h005F, 8'h00);
    check("top alias hit", 16'h0100, {rsp.hit, rsp.rdata});
    acc(iod_pkg::OP_IO_WRITE, 16'h0060, 8'h11);
    check("native op no ext", 16'h0000, {ext.wr, ext.rd});
    rd(16'h0020, 8'h11, "native field wraps");
    // reserved bits and locations read zero
    acc(iod_pkg::OP_IO_WRITE, 16'h001D, 8'hFF);
    rd(16'h001D, 8'h07, "reserved bits");
    rd(16'h003F, 8'h00, "reserved location");
    acc(iod_pkg::OP_IO_WRITE, 16'h001D, 8'h05);
    rd(16'h001D, 8'h05, "mask with reserved bits zero");
    // extended range goes out as data-space traffic only
    foreach (ext_a[i]) begin
      acc(iod_pkg::OP_MEM_WRITE, ext_a[i], 8'h5A);
      check("ext write", {5'h0, 2'b10, ext_a[i][7:0], 1'b0}, {ext.wr, ext.rd, ext.addr, rsp.hit});
      acc(iod_pkg::OP_MEM_READ, ext_a[i], 8'h00);
      check("ext read", {5'h0, 2'b01, ext_a[i][7:0], 1'b0}, {ext.wr, ext.rd, ext.addr, rsp.hit});
    end
    acc(iod_pkg::OP_MEM_READ, 16'h0100, 8'h00);
    check("beyond ext", 16'h0001, {ext.wr, ext.rd, rsp.hit, rsp.valid});
    // bit set, clear and skip on the low 32
    acc(iod_pkg::OP_SET_BIT, 16'h001E, 8'h03);
    acc(iod_pkg::OP_CLEAR_BIT, 16'h001E, 8'h00);
    rd(16'h001E, 8'hAC, "bit set and clear");
    for (int i = 0; i < 4; i++) begin
      acc(i[0] ? iod_pkg::OP_SKIP_IF_CLEAR : iod_pkg::OP_SKIP_IF_SET, 16'h001E,
          i[1] ? 8'h00 : 8'h02);
      check("skip test", {7'h0, ~(i[0] ^ i[1]), 8'hAC}, {rsp.skip, rsp.rdata});
    end
    // flags: one clears, zero keeps, bit op clears all read as one
    @(negedge ref_clk_i) hw_set[21] = 8'h07;
    @(negedge ref_clk_i) hw_set[21] = 8'h00;
    rd(16'h0015, 8'h07, "flags raised");
    acc(iod_pkg::OP_IO_WRITE, 16'h0015, 8'h02);
    acc(iod_pkg::OP_IO_WRITE, 16'h0015, 8'h00);
    rd(16'h0015, 8'h05, "flag write one");
    acc(iod_pkg::OP_CLEAR_BIT, 16'h0015, 8'h03);
    rd(16'h0015, 8'h00, "bit op clears flags");
    // pin location is read-only and follows the pins
    acc(iod_pkg::OP_IO_WRITE, 16'h0003, 8'hFF);
    rd(16'h0003, 8'h0F, "pins read-only");
    stop_test();
  end
endmodule
`default_nettype wire

// file: tb/iod_exec_model.sv
/* execution unit stand-in: one request per call, launched on the falling edge.
   assumes the decoder samples requests on the rising edge. */
`default_nettype none
module iod_exec_model (
  input wire logic ref_clk_i,
  output var iod_pkg::iod_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // one cycle of request, then idle so each answer stands alone
  task automatic issue(input iod_pkg::iod_op_t op, input logic [15:0] a,
                       input iod_pkg::iod_byte_t d);
    @(negedge ref_clk_i);
    req_o = '{op, a[5:0], a[4:0], d[2:0], a, d};
    // native I/O writes to reserved places are never issued
    if (op == iod_pkg::OP_IO_WRITE && a[5:0] inside {[6'h0C:6'h14], [6'h18:6'h1A], 6'h29,
        6'h2F, 6'h32, [6'h36:6'h3F]}) begin
      req_o.op = iod_pkg::OP_IDLE;
    end
    @(negedge ref_clk_i);
    req_o.op = iod_pkg::OP_IDLE;
  endtask
endmodule
`default_nettype wire

// file: tb/iod_io_space_properties.sv
/* port checker for the I/O space decoder.
   assumes one core clock and the active-high asynchronous reset. */
`default_nettype none
module iod_io_space_properties (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire iod_pkg::iod_req_t req_i,
  input wire iod_pkg::iod_ports_t pins_i,
  input wire iod_pkg::iod_image_t hw_set_i,
  input wire iod_pkg::iod_image_t hw_status_i,
  input wire iod_pkg::iod_rsp_t rsp_o,
  input wire iod_pkg::iod_ext_t ext_o,
  input wire iod_pkg::iod_image_t io_image_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // request classes; flag_idle keeps event pulses out of the flag checks
  wire logic mem_op = req_i.op inside {iod_pkg::OP_MEM_READ, iod_pkg::OP_MEM_WRITE};
  wire logic ext_hit = mem_op && req_i.data_addr inside {[16'h0060:16'h00FF]};
  wire logic alias_rd = req_i.op == iod_pkg::OP_MEM_READ
    && req_i.data_addr inside {[16'h0020:16'h005F]};
  wire logic flag_idle = hw_set_i[21] == 8'h00;
  sequence s_take;
    req_i.op != iod_pkg::OP_IDLE;
  endsequence
  sequence s_ext_take;
    ext_hit ##1 (ext_o.rd || ext_o.wr);
  endsequence
  AST_ANSWER: assert property (s_take |=> rsp_o.valid)
    else $error("no answer one cycle after a request");
  AST_ALIAS_DATA: assert property (alias_rd |=> rsp_o.hit
    && rsp_o.rdata == $past(io_image_o[req_i.data_addr[5:0] - 6'h20]))
    else $error("data-space alias read wrong location");
  AST_EXT_PULSE: assert property (ext_hit |=> !rsp_o.hit && (ext_o.rd || ext_o.wr))
    else $error("extended data address not passed on");
  AST_EXT_ADDR: assert property (s_ext_take |-> ext_o.addr == $past(req_i.data_addr[7:0]))
    else $error("extended address wrong");
  AST_NATIVE_NO_EXT: assert property (req_i.op != iod_pkg::OP_IDLE && !mem_op
    |=> !ext_o.rd && !ext_o.wr)
    else $error("native or bit op reached extended space");
  AST_SKIP: assert property (req_i.op == iod_pkg::OP_SKIP_IF_SET
    |=> rsp_o.skip == $past(io_image_o[req_i.bit_addr][req_i.bit_sel]))
    else $error("skip result differs from tested bit");
  AST_W1C_ZERO: assert property (req_i.op == iod_pkg::OP_IO_WRITE && req_i.io_addr == 6'h15
    && req_i.wdata == 8'h00 && flag_idle |=> $stable(io_image_o[21]))
    else $error("writing zero changed a flag");
  AST_BITOP_RMW: assert property (req_i.op inside {iod_pkg::OP_SET_BIT,
    iod_pkg::OP_CLEAR_BIT} && req_i.bit_addr == 5'h15 && flag_idle |=> io_image_o[21] == 8'h00)
    else $error("bit op left a flag set");
  AST_RESERVED: assert property (req_i.op == iod_pkg::OP_IO_READ && req_i.io_addr == 6'h3F
    |=> rsp_o.rdata == 8'h00)
    else $error("reserved location read nonzero");
endmodule
bind iod_io_space iod_io_space_properties chk_u (.ref_clk_i, .sys_rst_i, .req_i, .pins_i,
  .hw_set_i, .hw_status_i, .rsp_o, .ext_o, .io_image_o);
`default_nettype wire

// file: verilog/iod_io_space.sv
/*
  Decoder and access logic of the 64-location I/O register space: native port
  reads and writes, data-space aliases, bit set, clear and test, flag clearing.
  Assumes requests come from the execution unit on ref_clk_i, one per cycle,
  and that peripherals drive their event and level inputs on the same clock.
*/
`default_nettype none
module iod_io_space (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire iod_pkg::iod_req_t req_i,
  input wire iod_pkg::iod_ports_t pins_i,
  input wire iod_pkg::iod_image_t hw_set_i,
  input wire iod_pkg::iod_image_t hw_status_i,
  output iod_pkg::iod_rsp_t rsp_o,
  output iod_pkg::iod_ext_t ext_o,
  output iod_pkg::iod_image_t io_image_o
);

  iod_pkg::iod_state_t st;
  iod_pkg::iod_state_t next_st;

  // readable view of one location, reserved bits forced low
  function automatic iod_pkg::iod_byte_t read_io(input iod_pkg::iod_image_t regs,
                                                 input iod_pkg::iod_addr_t a);
    return regs[a] & iod_pkg::impl_mask(a);
  endfunction

  // whole next state; response and extended request are one-cycle pulses
  always_comb begin
    iod_pkg::iod_addr_t sel;
    iod_pkg::iod_addr_t idx;
    iod_pkg::iod_byte_t cur;
    iod_pkg::iod_byte_t wval;
    logic [iod_pkg::DATA_W-1:0] rel;
    logic in_io;
    logic do_wr;
    sel = '0;
    idx = '0;
    cur = '0;
    wval = '0;
    rel = '0;
    in_io = 1'b0;
    do_wr = 1'b0;
    next_st = st;
    next_st.rsp = '0;
    next_st.ext = '0;

    // pins pass three flops (two sync stages, then the image) before any read; first stage feeds only the second
    next_st.pin_meta = pins_i;
    next_st.pin_sync = st.pin_meta;

    // address decode: which native location, if any, the request names
    case (req_i.op)
      iod_pkg::OP_IO_READ, iod_pkg::OP_IO_WRITE: begin
        sel = req_i.io_addr;
        in_io = 1'b1;
      end
      iod_pkg::OP_MEM_READ, iod_pkg::OP_MEM_WRITE: begin
        rel = req_i.data_addr - iod_pkg::DATA_IO_FIRST;
        if (req_i.data_addr >= iod_pkg::DATA_IO_FIRST &&
            req_i.data_addr <= iod_pkg::DATA_IO_LAST) begin
          sel = rel[iod_pkg::IO_ADDR_W-1:0];
          in_io = 1'b1;
        end
      end
      iod_pkg::OP_SET_BIT, iod_pkg::OP_CLEAR_BIT,
      iod_pkg::OP_SKIP_IF_SET, iod_pkg::OP_SKIP_IF_CLEAR: begin
        // five-bit field cannot name anything above 0x1F
        sel = {1'b0, req_i.bit_addr};
        in_io = 1'b1;
      end
      default: begin
        in_io = 1'b0;
      end
    endcase

    cur = read_io(st.regs, sel);

    // action: read data, write value, skip decision, extended forward
    case (req_i.op)
      iod_pkg::OP_IO_READ: begin
        next_st.rsp.rdata = cur;
      end
      iod_pkg::OP_IO_WRITE: begin
        wval = req_i.wdata;
        do_wr = 1'b1;
      end
      iod_pkg::OP_MEM_READ: begin
        if (in_io) begin
          next_st.rsp.rdata = cur;
        end
        // extended range reached only from here and from OP_MEM_WRITE
        if (req_i.data_addr >= iod_pkg::DATA_EXT_FIRST &&
            req_i.data_addr <= iod_pkg::DATA_EXT_LAST) begin
          next_st.ext.rd = 1'b1;
          next_st.ext.addr = req_i.data_addr[7:0];
        end
      end
      iod_pkg::OP_MEM_WRITE: begin
        wval = req_i.wdata;
        do_wr = in_io;
        if (req_i.data_addr >= iod_pkg::DATA_EXT_FIRST &&
            req_i.data_addr <= iod_pkg::DATA_EXT_LAST) begin
          next_st.ext.wr = 1'b1;
          next_st.ext.addr = req_i.data_addr[7:0];
          next_st.ext.wdata = req_i.wdata;
        end
      end
      iod_pkg::OP_SET_BIT: begin
        // read-modify-write of the whole byte, as the core does it
        wval = cur;
        wval[req_i.bit_sel] = 1'b1;
        do_wr = 1'b1;
      end
      iod_pkg::OP_CLEAR_BIT: begin
        wval = cur;
        wval[req_i.bit_sel] = 1'b0;
        do_wr = 1'b1;
      end
      iod_pkg::OP_SKIP_IF_SET: begin
        next_st.rsp.skip = cur[req_i.bit_sel];
        next_st.rsp.rdata = cur;
      end
      iod_pkg::OP_SKIP_IF_CLEAR: begin
        next_st.rsp.skip = ~cur[req_i.bit_sel];
        next_st.rsp.rdata = cur;
      end
      default: begin
        do_wr = 1'b0;
      end
    endcase

    next_st.rsp.valid = (req_i.op != iod_pkg::OP_IDLE);
    next_st.rsp.hit = in_io;

    // flags read as one and written back as one get cleared here
    if (do_wr) begin
      next_st.regs[sel] = iod_pkg::apply_write(st.regs[sel], wval, sel);
    end

    // hardware levels, then events; an event in the clearing cycle wins
    for (int a = 0; a < iod_pkg::IO_LOCS; a++) begin
      idx = iod_pkg::iod_addr_t'(a);
      next_st.regs[a] = (next_st.regs[a] & ~iod_pkg::ro_mask(idx)) |
                        (hw_status_i[a] & iod_pkg::ro_mask(idx)) |
                        (hw_set_i[a] & iod_pkg::set_mask(idx));
    end

    // input-pin locations show the synchronised pins
    for (int k = 0; k < iod_pkg::PORT_COUNT; k++) begin
      idx = iod_pkg::iod_addr_t'(int'(iod_pkg::A_PORT_A_INPUT_PINS) + iod_pkg::PORT_STRIDE * k);
      next_st.regs[idx] = st.pin_sync[k];
    end
  end

  // single state register; reset clears every location
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign rsp_o = st.rsp;
  assign ext_o = st.ext;
  assign io_image_o = st.regs;

endmodule
`default_nettype wire
